// *** tfdec_pkg.sv ***
package tfdec_pkg;

    localparam int ADDR_W   = 11;
    localparam int DATA_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int INDEX_W  = 2;
    localparam int COUNT_W  = 9;
    localparam int PIN_W    = 7 + ADDR_W + DATA_W;

    // configuration index values
    localparam logic [INDEX_W-1:0] IDX_MEMORY     = 2'h0;
    localparam logic [INDEX_W-1:0] IDX_CONTIGUOUS = 2'h1;
    localparam logic [INDEX_W-1:0] IDX_PRIMARY    = 2'h2;
    localparam logic [INDEX_W-1:0] IDX_SECONDARY  = 2'h3;

    // task file offsets on the low address nibble
    localparam logic [3:0] OFS_DATA     = 4'h0;
    localparam logic [3:0] OFS_ERRFEAT  = 4'h1;
    localparam logic [3:0] OFS_SECCNT   = 4'h2;
    localparam logic [3:0] OFS_SECNUM   = 4'h3;
    localparam logic [3:0] OFS_CYLLO    = 4'h4;
    localparam logic [3:0] OFS_CYLHI    = 4'h5;
    localparam logic [3:0] OFS_DRVHD    = 4'h6;
    localparam logic [3:0] OFS_STATCMD  = 4'h7;
    localparam logic [3:0] OFS_DUPEVEN  = 4'h8;
    localparam logic [3:0] OFS_DUPODD   = 4'h9;
    localparam logic [3:0] OFS_DUPERR   = 4'hd;
    localparam logic [3:0] OFS_ALTCTL   = 4'he;
    localparam logic [3:0] OFS_DRVADDR  = 4'hf;

    // A9..A4 block codes of the ATA maps
    localparam logic [5:0] PRI_TASK_BLK = 6'h1f;
    localparam logic [5:0] PRI_ALT_BLK  = 6'h3f;
    localparam logic [5:0] SEC_TASK_BLK = 6'h17;
    localparam logic [5:0] SEC_ALT_BLK  = 6'h37;

    // address field positions
    localparam int A10_BIT   = 10;
    localparam int A3_BIT    = 3;
    localparam int A0_BIT    = 0;
    localparam int BLK_HI    = 9;
    localparam int BLK_LO    = 4;

    localparam logic [BYTE_W-1:0]  SECCNT_RESET = 8'h01;
    localparam logic [BYTE_W-1:0]  BYTE_ZERO    = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_ZERO_AS = 9'h100;
    localparam logic [PIN_W-1:0]   PIN_IDLE     = {{7{1'b1}}, {(ADDR_W+DATA_W){1'b0}}};

    typedef enum {
        SEL_NONE, SEL_DATA, SEL_ERRFEAT, SEL_SECCNT, SEL_SECNUM, SEL_CYLLO,
        SEL_CYLHI, SEL_DRVHD, SEL_STATCMD, SEL_EVEN, SEL_ODD, SEL_ALTCTL,
        SEL_DRVADDR
    } tfdec_sel_type;

    typedef struct packed {
        logic              reg_n;
        logic              oe_n;
        logic              we_n;
        logic              iord_n;
        logic              iowr_n;
        logic              ce1_n;
        logic              ce2_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } tfdec_pins_type;

    typedef struct packed {
        logic [BYTE_W-1:0] feature;
        logic [BYTE_W-1:0] sector_count;
        logic [BYTE_W-1:0] sector_number;
        logic [BYTE_W-1:0] cylinder_low;
        logic [BYTE_W-1:0] cylinder_high;
        logic [BYTE_W-1:0] drive_head;
        logic [BYTE_W-1:0] device_control;
    } tfdec_task_type;

endpackage

// *** tfdec_sync.sv ***
module tfdec_sync
    import tfdec_pkg::*;
#(
    parameter int             WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule

// *** tfdec_map.sv ***
module tfdec_map
    import tfdec_pkg::*;
(
    input  wire logic [INDEX_W-1:0] index_i,
    input  wire logic               reg_n_i,
    input  wire logic [ADDR_W-1:0]  addr_i,
    output tfdec_sel_type           sel_o
);

    function automatic tfdec_sel_type nibble_sel(input logic [3:0] ofs);
        tfdec_sel_type s;
        case (ofs)
            OFS_DATA:    s = SEL_DATA;
            OFS_ERRFEAT: s = SEL_ERRFEAT;
            OFS_SECCNT:  s = SEL_SECCNT;
            OFS_SECNUM:  s = SEL_SECNUM;
            OFS_CYLLO:   s = SEL_CYLLO;
            OFS_CYLHI:   s = SEL_CYLHI;
            OFS_DRVHD:   s = SEL_DRVHD;
            OFS_STATCMD: s = SEL_STATCMD;
            OFS_DUPEVEN: s = SEL_EVEN;
            OFS_DUPODD:  s = SEL_ODD;
            OFS_DUPERR:  s = SEL_ERRFEAT;
            OFS_ALTCTL:  s = SEL_ALTCTL;
            OFS_DRVADDR: s = SEL_DRVADDR;
            default:     s = SEL_NONE;
        endcase
        return s;
    endfunction

    function automatic tfdec_sel_type ata_sel(input logic [ADDR_W-1:0] a,
                                              input logic [5:0] task_blk,
                                              input logic [5:0] alt_blk);
        tfdec_sel_type s;
        s = SEL_NONE;
        if (a[BLK_HI:BLK_LO] == task_blk && !a[A3_BIT]) begin
            s = nibble_sel(a[3:0]);
        end else if (a[BLK_HI:BLK_LO] == alt_blk && a[3:0] == OFS_DRVHD) begin
            s = SEL_ALTCTL;
        end else if (a[BLK_HI:BLK_LO] == alt_blk && a[3:0] == OFS_STATCMD) begin
            s = SEL_DRVADDR;
        end
        return s;
    endfunction

    always_comb begin
        sel_o = SEL_NONE;
        case (index_i)
            IDX_MEMORY: begin
                if (reg_n_i) begin
                    if (addr_i[A10_BIT]) begin
                        sel_o = addr_i[A0_BIT] ? SEL_ODD : SEL_EVEN;
                    end else begin
                        sel_o = nibble_sel(addr_i[3:0]);
                    end
                end
            end
            IDX_CONTIGUOUS: begin
                if (!reg_n_i) begin
                    sel_o = nibble_sel(addr_i[3:0]);
                end
            end
            IDX_PRIMARY: begin
                if (!reg_n_i) begin
                    sel_o = ata_sel(addr_i, PRI_TASK_BLK, PRI_ALT_BLK);
                end
            end
            IDX_SECONDARY: begin
                if (!reg_n_i) begin
                    sel_o = ata_sel(addr_i, SEC_TASK_BLK, SEC_ALT_BLK);
                end
            end
            default: sel_o = SEL_NONE;
        endcase
    end

endmodule

// *** tfdec_top.sv ***
// What this block does
// - Configuration index picks one of four task file decode maps.
// - Index 0: memory space with REG high, A10 low, offset on A3..A0.
// - Offsets 8H,9H,DH,EH,FH give duplicate data, error, alt status, drive address.
// - Index 1: I/O space with REG low, A10..A4 ignored, same offsets.
// - Index 2: block 1FH gives task file, block 3FH offsets 6,7 alternates.
// - Index 3: block 17H gives task file, block 37H offsets 6,7 alternates.
// - Memory map with A10 high: A0 picks even or odd data window.
// - Sector count zero means 256 sectors; resets to 01H.
// - Data register is 16 bits, accessed by word or by byte.
module tfdec_top
    import tfdec_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic [INDEX_W-1:0]   config_index_i,
    input  wire logic                 reg_n_i,
    input  wire logic                 oe_n_i,
    input  wire logic                 we_n_i,
    input  wire logic                 iord_n_i,
    input  wire logic                 iowr_n_i,
    input  wire logic                 ce1_n_i,
    input  wire logic                 ce2_n_i,
    input  wire logic [ADDR_W-1:0]    addr_i,
    input  wire logic [DATA_W-1:0]    data_i,
    output logic      [DATA_W-1:0]    data_o,
    output logic                      data_oe_o,
    input  wire logic [BYTE_W-1:0]    status_i,
    input  wire logic [BYTE_W-1:0]    error_i,
    input  wire logic [BYTE_W-1:0]    drive_address_i,
    input  wire logic [DATA_W-1:0]    sector_word_i,
    output tfdec_task_type            task_o,
    output logic      [COUNT_W-1:0]   sector_total_o,
    output logic                      command_pulse_o,
    output logic      [BYTE_W-1:0]    command_o,
    output logic                      word_written_o,
    output logic      [DATA_W-1:0]    word_out_o,
    output logic                      word_taken_o
);

    typedef enum {ST_IDLE, ST_READ, ST_WRITE} tfdec_state_type;

    tfdec_pins_type  pins_raw;
    tfdec_pins_type  pins;
    tfdec_sel_type   sel;

    tfdec_state_type state_q;
    tfdec_state_type state_d;
    tfdec_sel_type   wsel_q;
    tfdec_sel_type   wsel_d;
    logic            wword_q;
    logic            wword_d;
    logic            whigh_q;
    logic            whigh_d;
    logic            rword_q;
    logic            rword_d;
    logic            rsel_data_q;
    logic            rsel_data_d;
    logic            rhigh_q;
    logic            rhigh_d;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] wdata_d;

    tfdec_task_type  task_q;
    tfdec_task_type  task_d;
    logic [DATA_W-1:0]  data_word_q;
    logic [DATA_W-1:0]  data_word_d;
    logic [COUNT_W-1:0] total_q;
    logic [COUNT_W-1:0] total_d;
    logic               cmd_pulse_q;
    logic               cmd_pulse_d;
    logic [BYTE_W-1:0]  cmd_q;
    logic [BYTE_W-1:0]  cmd_d;
    logic               wr_pulse_q;
    logic               wr_pulse_d;
    logic               rd_pulse_q;
    logic               rd_pulse_d;
    logic [DATA_W-1:0]  dout_q;
    logic [DATA_W-1:0]  dout_d;
    logic               doe_q;
    logic               doe_d;

    logic               rd_act;
    logic               wr_act;
    logic               word_acc;
    logic               high_lane;
    logic [BYTE_W-1:0]  rbyte;
    logic [BYTE_W-1:0]  wbyte;

    assign pins_raw = '{reg_n:  reg_n_i,
                        oe_n:   oe_n_i,
                        we_n:   we_n_i,
                        iord_n: iord_n_i,
                        iowr_n: iowr_n_i,
                        ce1_n:  ce1_n_i,
                        ce2_n:  ce2_n_i,
                        addr:   addr_i,
                        data:   data_i};

    // card pins are asynchronous to clk_i; address and data are sampled with the strobes
    tfdec_sync #(
        .WIDTH     (PIN_W),
        .RESET_VAL (PIN_IDLE)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .async_i  (pins_raw),
        .sync_o   (pins)
    );

    tfdec_map u_map (
        .index_i (config_index_i),
        .reg_n_i (pins.reg_n),
        .addr_i  (pins.addr),
        .sel_o   (sel)
    );

    // memory strobes in the memory map, I/O strobes in the others
    always_comb begin
        if (config_index_i == IDX_MEMORY) begin
            rd_act = !pins.oe_n;
            wr_act = !pins.we_n;
        end else begin
            rd_act = !pins.iord_n;
            wr_act = !pins.iowr_n;
        end
        word_acc  = !pins.ce1_n && !pins.ce2_n;
        high_lane = pins.ce1_n && !pins.ce2_n;
    end

    // eight-bit reads are mirrored on both lanes so either byte lane sees them
    always_comb begin
        case (sel)
            SEL_ERRFEAT: rbyte = error_i;
            SEL_SECCNT:  rbyte = task_q.sector_count;
            SEL_SECNUM:  rbyte = task_q.sector_number;
            SEL_CYLLO:   rbyte = task_q.cylinder_low;
            SEL_CYLHI:   rbyte = task_q.cylinder_high;
            SEL_DRVHD:   rbyte = task_q.drive_head;
            SEL_STATCMD: rbyte = status_i;
            SEL_ALTCTL:  rbyte = status_i;
            SEL_DRVADDR: rbyte = drive_address_i;
            SEL_EVEN:    rbyte = sector_word_i[BYTE_W-1:0];
            SEL_ODD:     rbyte = sector_word_i[DATA_W-1:BYTE_W];
            default:     rbyte = BYTE_ZERO;
        endcase
    end

    always_comb begin
        state_d     = state_q;
        wsel_d      = wsel_q;
        wword_d     = wword_q;
        whigh_d     = whigh_q;
        wdata_d     = wdata_q;
        rword_d     = rword_q;
        rsel_data_d = rsel_data_q;
        rhigh_d     = rhigh_q;
        rd_pulse_d  = 1'b0;
        dout_d      = dout_q;
        doe_d       = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (wr_act) begin
                    state_d = ST_WRITE;
                end else if (rd_act) begin
                    state_d = ST_READ;
                end
            end
            ST_READ: begin
                if (rd_act) begin
                    doe_d       = 1'b1;
                    rword_d     = word_acc;
                    rsel_data_d = (sel == SEL_DATA) || (sel == SEL_ODD);
                    rhigh_d     = high_lane;
                    if (sel == SEL_DATA && word_acc) begin
                        dout_d = sector_word_i;
                    end else if (sel == SEL_DATA) begin
                        dout_d = {sector_word_i[BYTE_W-1:0], sector_word_i[BYTE_W-1:0]};
                    end else begin
                        dout_d = {rbyte, rbyte};
                    end
                end else begin
                    // a word, or a low-lane byte from the data register or odd window, completes one data word toward the core
                    // lane comes from the strobe-low samples, the enables may move at release
                    rd_pulse_d = rsel_data_q && (rword_q || !rhigh_q);
                    state_d    = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (wr_act) begin
                    // keep the last sample seen while the strobe was low
                    wsel_d  = sel;
                    wword_d = word_acc;
                    whigh_d = high_lane;
                    wdata_d = pins.data;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // register writes happen on the strobe release
    always_comb begin
        task_d      = task_q;
        data_word_d = data_word_q;
        cmd_d       = cmd_q;
        cmd_pulse_d = 1'b0;
        wr_pulse_d  = 1'b0;
        wbyte       = whigh_q ? wdata_q[DATA_W-1:BYTE_W] : wdata_q[BYTE_W-1:0];
        if (state_q == ST_WRITE && !wr_act) begin
            case (wsel_q)
                SEL_DATA: begin
                    if (wword_q) begin
                        data_word_d = wdata_q;
                        wr_pulse_d  = 1'b1;
                    end else begin
                        data_word_d[BYTE_W-1:0] = wbyte;
                    end
                end
                SEL_EVEN:    data_word_d[BYTE_W-1:0] = wbyte;
                SEL_ODD: begin
                    data_word_d[DATA_W-1:BYTE_W] = wbyte;
                    wr_pulse_d = 1'b1;
                end
                SEL_ERRFEAT: task_d.feature       = wbyte;
                SEL_SECCNT:  task_d.sector_count  = wbyte;
                SEL_SECNUM:  task_d.sector_number = wbyte;
                SEL_CYLLO:   task_d.cylinder_low  = wbyte;
                SEL_CYLHI:   task_d.cylinder_high = wbyte;
                SEL_DRVHD:   task_d.drive_head    = wbyte;
                SEL_ALTCTL:  task_d.device_control = wbyte;
                SEL_STATCMD: begin
                    cmd_d       = wbyte;
                    cmd_pulse_d = 1'b1;
                end
                default: begin
                    // drive address write slot is reserved; unmapped writes are dropped
                    task_d = task_q;
                end
            endcase
        end
        if (task_d.sector_count == BYTE_ZERO) begin
            total_d = COUNT_ZERO_AS;
        end else begin
            total_d = {1'b0, task_d.sector_count};
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q     <= ST_IDLE;
            wsel_q      <= SEL_NONE;
            wword_q     <= 1'b0;
            whigh_q     <= 1'b0;
            wdata_q     <= '0;
            rword_q     <= 1'b0;
            rsel_data_q <= 1'b0;
            rhigh_q     <= 1'b0;
            rd_pulse_q  <= 1'b0;
            dout_q      <= '0;
            doe_q       <= 1'b0;
            task_q      <= '{sector_count: SECCNT_RESET, default: BYTE_ZERO};
            data_word_q <= '0;
            total_q     <= {1'b0, SECCNT_RESET};
            cmd_q       <= BYTE_ZERO;
            cmd_pulse_q <= 1'b0;
            wr_pulse_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            wsel_q      <= wsel_d;
            wword_q     <= wword_d;
            whigh_q     <= whigh_d;
            wdata_q     <= wdata_d;
            rword_q     <= rword_d;
            rsel_data_q <= rsel_data_d;
            rhigh_q     <= rhigh_d;
            rd_pulse_q  <= rd_pulse_d;
            dout_q      <= dout_d;
            doe_q       <= doe_d;
            task_q      <= task_d;
            data_word_q <= data_word_d;
            total_q     <= total_d;
            cmd_q       <= cmd_d;
            cmd_pulse_q <= cmd_pulse_d;
            wr_pulse_q  <= wr_pulse_d;
        end
    end

    assign data_o          = dout_q;
    assign data_oe_o       = doe_q;
    assign task_o          = task_q;
    assign sector_total_o  = total_q;
    assign command_pulse_o = cmd_pulse_q;
    assign command_o       = cmd_q;
    assign word_written_o  = wr_pulse_q;
    assign word_out_o      = data_word_q;
    assign word_taken_o    = rd_pulse_q;

endmodule

// *** tfdec_props.sv ***
module tfdec_props
    import tfdec_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 oe_n_i,
    input  wire logic                 we_n_i,
    input  wire logic                 iord_n_i,
    input  wire logic                 iowr_n_i,
    input  wire logic                 data_oe_o,
    input  wire tfdec_task_type       task_o,
    input  wire logic [COUNT_W-1:0]   sector_total_o,
    input  wire logic                 command_pulse_o,
    input  wire logic                 word_written_o,
    input  wire logic                 word_taken_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // five idle samples cover the two sync flops plus the registered drop
    sequence s_read_idle;
        (oe_n_i && iord_n_i) [*5];
    endsequence
    sequence s_write_released;
        $past(we_n_i, 2) && $past(iowr_n_i, 2);
    endsequence
    a_oe_needs_read: assert property (
        $rose(data_oe_o) |-> (!$past(oe_n_i, 2) || !$past(iord_n_i, 2)))
        else $error("data driven without a read strobe");
    a_oe_released: assert property (s_read_idle |-> !data_oe_o)
        else $error("data still driven after read ended");
    a_cmd_pulse_one: assert property (command_pulse_o |=> !command_pulse_o)
        else $error("command pulse longer than one cycle");
    a_cmd_after_release: assert property (command_pulse_o |-> s_write_released)
        else $error("command taken before write strobe released");
    a_word_pulse_one: assert property (word_written_o |=> !word_written_o)
        else $error("word written pulse too long");
    a_taken_pulse_one: assert property (word_taken_o |=> !word_taken_o)
        else $error("word taken pulse too long");
    a_zero_means_full: assert property ($stable(task_o.sector_count) |->
        sector_total_o == ((task_o.sector_count == BYTE_ZERO) ? COUNT_ZERO_AS
        : {1'b0, task_o.sector_count}))
        else $error("sector total does not follow sector count");
    a_count_reset: assert property ($rose(resetn_i) |->
        task_o.sector_count == SECCNT_RESET && !data_oe_o)
        else $error("sector count not at its reset value");
    a_write_no_drive: assert property (word_written_o |-> !data_oe_o)
        else $error("data driven during a write");
endmodule

bind tfdec_top tfdec_props u_props (.clk_i, .resetn_i, .oe_n_i, .we_n_i, .iord_n_i,
    .iowr_n_i, .data_oe_o, .task_o, .sector_total_o, .command_pulse_o, .word_written_o,
    .word_taken_o);

// *** tfdec_host_model.sv ***
module tfdec_host_model
    import tfdec_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output tfdec_pins_type         pins_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        pins_o = PIN_IDLE;
    end
    // one strobe at a time, six cycles low, long recovery: the host side order
    task automatic access(input logic wr, input logic io, input logic regn,
            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [1:0] ce, output logic [DATA_W-1:0] q);
        @(negedge clk_i);
        pins_o.reg_n = regn;
        pins_o.addr = a;
        pins_o.data = d;
        {pins_o.ce2_n, pins_o.ce1_n} = ce;
        pins_o.we_n = !(wr && !io);
        pins_o.oe_n = !(!wr && !io);
        pins_o.iowr_n = !(wr && io);
        pins_o.iord_n = !(!wr && io);
        repeat (6) @(negedge clk_i);
        q = rdata_i;
        {pins_o.oe_n, pins_o.we_n, pins_o.iord_n, pins_o.iowr_n} = 4'hf;
        repeat (4) @(negedge clk_i);
        // a released bus must not keep showing the last word
        pins_o.data = ~d;
        {pins_o.ce2_n, pins_o.ce1_n} = 2'h3;
        repeat (3) @(negedge clk_i);
    endtask
endmodule

// *** task_file_address_decoder_tb_top.sv ***
module task_file_address_decoder_tb_top;
    import tfdec_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk_i;
    logic                 resetn_i;
    logic [INDEX_W-1:0]   config_index_i;
    logic [BYTE_W-1:0]    status_i;
    logic [BYTE_W-1:0]    error_i;
    logic [BYTE_W-1:0]    drive_address_i;
    logic [DATA_W-1:0]    sector_word_i;
    logic [DATA_W-1:0]    data_o;
    logic                 data_oe_o;
    tfdec_pins_type       pins;
    tfdec_task_type       task_o;
    logic [COUNT_W-1:0]   sector_total_o;
    logic                 command_pulse_o;
    logic [BYTE_W-1:0]    command_o;
    logic                 word_written_o;
    logic [DATA_W-1:0]    word_out_o;
    logic                 word_taken_o;
    int                   fail_count;
    int                   samples_checked;
    int                   cycles;
    int                   cmd_seen;
    int                   word_seen;
    int                   taken_seen;

    tfdec_top u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .config_index_i(config_index_i),
        .reg_n_i(pins.reg_n), .oe_n_i(pins.oe_n), .we_n_i(pins.we_n), .iord_n_i(pins.iord_n),
        .iowr_n_i(pins.iowr_n), .ce1_n_i(pins.ce1_n), .ce2_n_i(pins.ce2_n),
        .addr_i(pins.addr), .data_i(pins.data), .data_o(data_o), .data_oe_o(data_oe_o),
        .status_i(status_i), .error_i(error_i), .drive_address_i(drive_address_i),
        .sector_word_i(sector_word_i), .task_o(task_o), .sector_total_o(sector_total_o),
        .command_pulse_o(command_pulse_o), .command_o(command_o),
        .word_written_o(word_written_o), .word_out_o(word_out_o), .word_taken_o(word_taken_o));
    tfdec_host_model u_host (.clk_i(clk_i), .rdata_i(data_o), .pins_o(pins));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_sim();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (command_pulse_o === 1'b1) cmd_seen++;
        if (word_written_o === 1'b1) word_seen++;
        if (word_taken_o === 1'b1) taken_seen++;
        // about 1330 cycles of traffic are expected
        if (cycles == 6000) begin
            fail_count++;
            end_sim();
        end
    end

    function automatic logic [ADDR_W-1:0] addr_of(input logic [1:0] ix, input logic [3:0] ofs,
            input logic [ADDR_W-1:0] r);
        logic [5:0] blk;
        blk = (ix == IDX_PRIMARY) ? ((ofs < 4'h8) ? PRI_TASK_BLK : PRI_ALT_BLK)
            : ((ofs < 4'h8) ? SEC_TASK_BLK : SEC_ALT_BLK);
        case (ix)
            IDX_MEMORY: addr_of = {1'b0, r[9:4], ofs};
            IDX_CONTIGUOUS: addr_of = {r[10:4], ofs};
            default: addr_of = {r[10], blk, 1'b0, ofs[2:0]};
        endcase
    endfunction

    task automatic acc(input logic wr, input logic [1:0] ix, input logic [3:0] ofs,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(negedge clk_i);
        config_index_i = ix;
        u_host.access(wr, ix != IDX_MEMORY, ix == IDX_MEMORY, addr_of(ix, ofs, 11'($urandom)),
            d, 2'h0, q);
    endtask

    initial begin
        logic [DATA_W-1:0] q;
        logic [BYTE_W-1:0] v;
        logic [BYTE_W-1:0] w;
        logic [ADDR_W-1:0] r;
        tfdec_task_type    snap;
        void'($urandom(32'haee6c5e7));
        resetn_i = 1'b0;
        config_index_i = IDX_MEMORY;
        status_i = 8'($urandom);
        error_i = 8'($urandom);
        drive_address_i = 8'($urandom);
        sector_word_i = 16'($urandom);
        repeat (20) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check(task_o.sector_count, SECCNT_RESET);
        check(sector_total_o, 9'h001);
        check(data_oe_o, 1'b0);
        for (int ix = 0; ix < 4; ix++) begin
            for (int o = 1; o < 7; o++) begin
                v = 8'($urandom);
                acc(1'b1, 2'(ix), 4'(o), {v, v}, q);
                check(task_o[8*(7-o) +: 8], v);
                acc(1'b0, 2'(ix), 4'(o), 16'h0000, q);
                check(q, (o == 1) ? {error_i, error_i} : {v, v});
            end
            acc(1'b0, 2'(ix), OFS_STATCMD, 16'h0000, q);
            check(q, {status_i, status_i});
            acc(1'b0, 2'(ix), OFS_ALTCTL, 16'h0000, q);
            check(q, {status_i, status_i});
            acc(1'b0, 2'(ix), OFS_DRVADDR, 16'h0000, q);
            check(q, {drive_address_i, drive_address_i});
            v = 8'($urandom);
            acc(1'b1, 2'(ix), OFS_ALTCTL, {v, v}, q);
            check(task_o.device_control, v);
            w = 8'($urandom);
            r = 11'(cmd_seen);
            acc(1'b1, 2'(ix), OFS_STATCMD, {w, w}, q);
            check(command_o, w);
            check(cmd_seen, r + 11'h001);
            if (ix < 2) begin
                acc(1'b1, 2'(ix), OFS_DUPERR, {v, v}, q);
                check(task_o.feature, v);
                acc(1'b0, 2'(ix), OFS_DUPERR, 16'h0000, q);
                check(q, {error_i, error_i});
                acc(1'b0, 2'(ix), 4'ha, 16'h0000, q);
                check(q, 16'h0000);
                snap = task_o;
                acc(1'b1, 2'(ix), 4'hb, 16'hffff, q);
                check(task_o, snap);
            end
        end
        acc(1'b1, IDX_CONTIGUOUS, OFS_SECCNT, 16'h0000, q);
        check(sector_total_o, 9'h100);
        snap = task_o;
        for (int k = 0; k < 3; k++) begin
            @(negedge clk_i);
            config_index_i = 2'(k);
            r = (k == 2) ? 11'h1e2 : 11'h002;
            u_host.access(1'b1, 1'b0, 1'b0, r, 16'h5a5a, 2'h0, q);
        end
        check(task_o, snap);
        for (int k = 0; k < 2; k++) begin
            r = 11'($urandom);
            v = 8'($urandom);
            w = 8'($urandom);
            @(negedge clk_i);
            config_index_i = IDX_MEMORY;
            u_host.access(1'b1, 1'b0, 1'b1, k ? {1'b1, r[9:1], 1'b0} : {1'b0, r[9:4],
                OFS_DUPEVEN}, {~v, v}, 2'h2, q);
            u_host.access(1'b1, 1'b0, 1'b1, k ? {1'b1, r[9:1], 1'b1} : {1'b0, r[9:4],
                OFS_DUPODD}, {~w, w}, 2'h2, q);
            check(word_out_o, {w, v});
        end
        // high byte lane alone: the odd lane carries the byte
        @(negedge clk_i);
        config_index_i = IDX_CONTIGUOUS;
        u_host.access(1'b1, 1'b1, 1'b0, {r[10:4], OFS_CYLLO}, {w, ~w}, 2'h1, q);
        check(task_o.cylinder_low, w);
        r = 11'(word_seen);
        acc(1'b1, IDX_MEMORY, OFS_DATA, 16'hc3a5, q);
        check(word_out_o, 16'hc3a5);
        check(word_seen, r + 11'h001);
        sector_word_i = 16'($urandom);
        r = 11'(taken_seen);
        acc(1'b0, IDX_PRIMARY, OFS_DATA, 16'h0000, q);
        check(q, sector_word_i);
        check(taken_seen, r + 11'h001);
        end_sim();
    end
endmodule
